// ==== logic/scwd_pkg.sv ====
// Package of the system control and watchdog block
// Assumes a 20 MHz core clock and a word-wide AHB-Lite register bus
package scwd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYS_CTRL = 8'h03;
  localparam logic [7:0] IDX_WD_CTRL  = 8'h0a;
  localparam logic [7:0] IDX_SYS_STAT = 8'h0c;

  // System control fields
  localparam int BIT_PSE      = 7;
  localparam int BIT_EDGE_HI  = 6;
  localparam int BIT_EDGE_LO  = 5;
  localparam int BIT_STOP_REQ = 0;

  // System status fields
  localparam int BIT_LIN_CL    = 6;
  localparam int BIT_SWITCHED_OUTPUT_OVERCURRENT_FLAG  = 5;
  localparam int BIT_LOW_VOLT  = 3;
  localparam int BIT_HIGH_VOLT = 2;
  localparam int BIT_BRG_OCF   = 1;
  localparam int BIT_OVER_TEMP = 0;

  // Watchdog control fields
  localparam int BIT_WD_RESTART = 5;
  localparam int BIT_WD_RST_EN  = 4;
  localparam int BIT_WD_WAKE_EN = 3;
  localparam int BIT_WD_RATE    = 0;

  // Reset values
  localparam logic [1:0] RST_EDGE_SEL = 2'h0;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // Watchdog periods
  localparam int CLK_HZ       = 20000000;
  localparam int WD_FAST_MS   = 10;
  localparam int WD_SLOW_MS   = 20;
  localparam int WD_FAST_CYC  = CLK_HZ / 1000 * WD_FAST_MS;
  localparam int WD_SLOW_CYC  = CLK_HZ / 1000 * WD_SLOW_MS;
  localparam int WD_CNT_W     = 19;

  // Edge rate codes
  typedef enum logic [1:0] {
    SCWD_EDGE_20K = 2'h0,
    SCWD_EDGE_10K = 2'h1,
    SCWD_EDGE_HS8 = 2'h2,
    SCWD_EDGE_HS4 = 2'h3
  } scwd_edge_e;

  // Bus slave states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR   = 4'b0010,
    ST_RD1  = 4'b0100,
    ST_RD2  = 4'b1000
  } scwd_bus_e;

  // Conditions reported by the analog side
  typedef struct packed {
    logic hvddOverCur;
    logic highOverCur;
    logic lowOverCur;
    logic linCurLim;
    logic lowVolt;
    logic highVolt;
    logic overTemp;
  } scwd_sense_s;

  // Gates and commands toward the power stages
  typedef struct packed {
    logic       hvddEnable;
    logic       highSideEnable;
    logic       lowSideEnable;
    logic       linTxEnable;
    scwd_edge_e linEdgeSel;
  } scwd_stage_s;

endpackage

// ==== logic/scwd_top.sv ====
// System control, status and watchdog registers with the watchdog timer
// Assumes an AHB-Lite master on core_clk, sense inputs synchronous to it
// Sense inputs are levels from the analog side, already in this domain
// Watchdog periods are counted in core_clk cycles
// The watchdog reset output is a request only; system rst clears this block
//
// Overview of operation
// - Switched output overcurrent turns output off, flags
// - Power stage enable gates all stages, reset clears
// - Two-bit field selects LIN edge rate
// - Stop request write enters stop; interrupt clears
// - LIN current limit bit shows transmitter state
// - Write one clears switched output flag, re-enables
// - Low and high voltage bits mirror flags
// - Overtemperature bit mirrors interrupt flag
// - Write one clears bridge flag, re-enables bridge
// - Watchdog runs only with an enable set
// - Reset enable cannot be disabled by software
// - Timeout with reset enable asserts reset output
// - Reset counting freezes in stop mode
// - Restart write restarts period, reads zero
// - Reset enable settable once per reset
// - Wake enable wakes from stop periodically
// - Watchdog interrupt only while in stop
// - Rate bit selects 10 ms or 20 ms
// - Side overcurrent turns off whole side, flags
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns

module scwd_top #(
  parameter int WD_FAST = scwd_pkg::WD_FAST_CYC,
  parameter int WD_SLOW = scwd_pkg::WD_SLOW_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire scwd_pkg::scwd_sense_s sense,
  input  wire logic                  cpuIrqReq,
  output scwd_pkg::scwd_stage_s      stage,
  output logic                       stopMode,
  output logic                       wdResetOut,
  output logic                       wdIrq
);

  ////////////////////////////////////////////////////////////////////
  // Address decode

  // Word index from a byte address, misaligned or out-of-range yields all ones
  // Upper address bits must be zero so aliases never hit a register
  function automatic logic [7:0] regIndex(input logic [31:0] a);
    logic [7:0] idx;
    idx = 8'hff;
    if (a[1:0] == 2'h0 && a[31:10] == 22'h00_0000)
    begin
      idx = a[9:2];
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus slave state
  // Address is held from the address phase into the data phase

  scwd_pkg::scwd_bus_e busSt_r;
  scwd_pkg::scwd_bus_e busSt_nxt;
  logic [7:0]          addr_r;
  logic [7:0]          addr_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  logic                takeReq;
  logic                wrStb;
  logic [7:0]          wByte;

  // Register state
  // Side-off bits remember which side tripped
  logic                pse_r;
  logic                pse_nxt;
  logic [1:0]          edgeSel_r;
  logic [1:0]          edgeSel_nxt;
  logic                stop_r;
  logic                stop_nxt;
  logic                hvddOcf_r;
  logic                hvddOcf_nxt;
  logic                brgOcf_r;
  logic                brgOcf_nxt;
  logic                highOff_r;
  logic                highOff_nxt;
  logic                lowOff_r;
  logic                lowOff_nxt;
  logic                wdRe_r;
  logic                wdRe_nxt;
  logic                wdIe_r;
  logic                wdIe_nxt;
  logic                wdRate_r;
  logic                wdRate_nxt;

  // Watchdog state
  logic [scwd_pkg::WD_CNT_W-1:0] wdCnt_r;
  logic [scwd_pkg::WD_CNT_W-1:0] wdCnt_nxt;
  logic [scwd_pkg::WD_CNT_W-1:0] wdEnd;
  logic                          wdRst_r;
  logic                          wdRst_nxt;
  logic                          wdIrq_r;
  logic                          wdIrq_nxt;
  logic                          wdRun;
  logic                          wdCount;
  logic                          wdRestart;
  logic                          wdHit;

  // Read image of every register
  // Built from the live state, never latched
  logic [7:0] sysCtrlRd;
  logic [7:0] sysStatRd;
  logic [7:0] wdCtrlRd;

  ////////////////////////////////////////////////////////////////////
  // Bus handshake; reads take one wait state
  // The wait state lets hrdata come straight from a flop
  // Writes need none: they commit at the end of the data phase
  // Every transfer is answered OKAY, unmapped ones included

  assign takeReq   = hsel && htrans[1] && hready;
  assign wrStb     = (busSt_r == scwd_pkg::ST_WR);
  assign wByte     = hwdata[7:0];
  assign hreadyout = (busSt_r != scwd_pkg::ST_RD1);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // Read images
  // Write-only bits and unused positions always read zero
  assign sysCtrlRd = {pse_r, edgeSel_r, 5'h00};
  assign sysStatRd = {1'b0, sense.linCurLim, hvddOcf_r, 1'b0,
                      sense.lowVolt, sense.highVolt,
                      brgOcf_r, sense.overTemp};
  assign wdCtrlRd  = {3'h0, wdRe_r, wdIe_r, 2'h0, wdRate_r};

  // Next bus state and read data
  // The image is captured in the wait cycle and reflects that cycle
  always_comb
  begin
    busSt_nxt = busSt_r;
    addr_nxt  = addr_r;
    rdata_nxt = rdata_r;
    if (busSt_r == scwd_pkg::ST_RD1)
    begin
      busSt_nxt = scwd_pkg::ST_RD2;
      case (addr_r)
        scwd_pkg::IDX_SYS_CTRL: rdata_nxt = {24'h00_0000, sysCtrlRd};
        scwd_pkg::IDX_SYS_STAT: rdata_nxt = {24'h00_0000, sysStatRd};
        scwd_pkg::IDX_WD_CTRL:  rdata_nxt = {24'h00_0000, wdCtrlRd};
        default:                rdata_nxt = 32'h0000_0000;
      endcase
    end
    else if (takeReq)
    begin
      addr_nxt  = regIndex(haddr);
      busSt_nxt = hwrite ? scwd_pkg::ST_WR : scwd_pkg::ST_RD1;
    end
    else
    begin
      busSt_nxt = scwd_pkg::ST_IDLE;
    end
  end

  // Bus registers
  // Reset leaves the bus idle and ready
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busSt_r <= scwd_pkg::ST_IDLE;
      addr_r  <= 8'hff;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      busSt_r <= busSt_nxt;
      addr_r  <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and status registers

  // Next values of the control and status bits
  // Order matters: interrupt clear, then software write, then hardware set
  always_comb
  begin
    pse_nxt     = pse_r;
    edgeSel_nxt = edgeSel_r;
    stop_nxt    = stop_r;
    hvddOcf_nxt = hvddOcf_r;
    brgOcf_nxt  = brgOcf_r;
    highOff_nxt = highOff_r;
    lowOff_nxt  = lowOff_r;
    wdRe_nxt    = wdRe_r;
    wdIe_nxt    = wdIe_r;
    wdRate_nxt  = wdRate_r;
    // Interrupt requests end stop mode
    if (cpuIrqReq || wdIrq_r)
    begin
      stop_nxt = 1'b0;
    end
    if (wrStb)
    begin
      case (addr_r)
        scwd_pkg::IDX_SYS_CTRL:
        begin
          pse_nxt     = wByte[scwd_pkg::BIT_PSE];
          edgeSel_nxt = wByte[scwd_pkg::BIT_EDGE_HI:
                              scwd_pkg::BIT_EDGE_LO];
          if (wByte[scwd_pkg::BIT_STOP_REQ])
          begin
            stop_nxt = 1'b1;
          end
        end
        scwd_pkg::IDX_SYS_STAT:
        begin
          // Ones clear, zeros leave the flags alone
          if (wByte[scwd_pkg::BIT_SWITCHED_OUTPUT_OVERCURRENT_FLAG])
          begin
            hvddOcf_nxt = 1'b0;
          end
          if (wByte[scwd_pkg::BIT_BRG_OCF])
          begin
            brgOcf_nxt  = 1'b0;
            highOff_nxt = 1'b0;
            lowOff_nxt  = 1'b0;
          end
        end
        scwd_pkg::IDX_WD_CTRL:
        begin
          // Set only; no write can clear it
          wdRe_nxt   = wdRe_r | wByte[scwd_pkg::BIT_WD_RST_EN];
          wdIe_nxt   = wByte[scwd_pkg::BIT_WD_WAKE_EN];
          wdRate_nxt = wByte[scwd_pkg::BIT_WD_RATE];
        end
        default:
        begin
          pse_nxt = pse_r;
        end
      endcase
    end
    // Hardware sets win over software clears
    // Each side goes off as a whole; the bridge flag covers both
    if (sense.hvddOverCur)
    begin
      hvddOcf_nxt = 1'b1;
    end
    if (sense.highOverCur)
    begin
      highOff_nxt = 1'b1;
      brgOcf_nxt  = 1'b1;
    end
    if (sense.lowOverCur)
    begin
      lowOff_nxt = 1'b1;
      brgOcf_nxt = 1'b1;
    end
  end

  // Register bank flops
  // Synchronous reset clears every bit
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pse_r     <= 1'b0;
      edgeSel_r <= scwd_pkg::RST_EDGE_SEL;
      stop_r    <= 1'b0;
      hvddOcf_r <= 1'b0;
      brgOcf_r  <= 1'b0;
      highOff_r <= 1'b0;
      lowOff_r  <= 1'b0;
      wdRe_r    <= 1'b0;
      wdIe_r    <= 1'b0;
      wdRate_r  <= 1'b0;
    end
    else
    begin
      pse_r     <= pse_nxt;
      edgeSel_r <= edgeSel_nxt;
      stop_r    <= stop_nxt;
      hvddOcf_r <= hvddOcf_nxt;
      brgOcf_r  <= brgOcf_nxt;
      highOff_r <= highOff_nxt;
      lowOff_r  <= lowOff_nxt;
      wdRe_r    <= wdRe_nxt;
      wdIe_r    <= wdIe_nxt;
      wdRate_r  <= wdRate_nxt;
    end
  end

  // Stage gating
  // Outputs drop in the cycle after an overcurrent is seen
  assign stage.hvddEnable     = pse_r && !hvddOcf_r;
  assign stage.highSideEnable = pse_r && !highOff_r;
  assign stage.lowSideEnable  = pse_r && !lowOff_r;
  assign stage.linTxEnable    = pse_r;
  assign stage.linEdgeSel     = scwd_pkg::scwd_edge_e'(edgeSel_r);
  assign stopMode             = stop_r;

  ////////////////////////////////////////////////////////////////////
  // Watchdog timer
  // One counter serves both the reset and the wake period
  // A restart write and a disable both zero it at once

  assign wdRun     = wdRe_r || wdIe_r;
  assign wdRestart = wrStb && (addr_r == scwd_pkg::IDX_WD_CTRL)
                     && wByte[scwd_pkg::BIT_WD_RESTART];
  assign wdEnd     = wdRate_r ? scwd_pkg::WD_CNT_W'(WD_FAST - 1)
                              : scwd_pkg::WD_CNT_W'(WD_SLOW - 1);
  // Stop freezes reset counting; wake counting goes on
  // Reset pulses are only ever raised in run mode
  assign wdCount   = wdRun && (stop_r ? wdIe_r : 1'b1);
  assign wdHit     = wdCount && (wdCnt_r >= wdEnd);

  // Counter, reset pulse and wake request
  // Reset pulse lasts one cycle; wake request lasts until stop ends
  always_comb
  begin
    wdCnt_nxt = wdCnt_r;
    wdRst_nxt = 1'b0;
    wdIrq_nxt = wdIrq_r && stop_r;
    if (!wdRun || wdRestart)
    begin
      wdCnt_nxt = '0;
    end
    else if (wdHit)
    begin
      wdCnt_nxt = '0;
      wdRst_nxt = wdRe_r && !stop_r;
      wdIrq_nxt = wdIe_r && stop_r;
    end
    else if (wdCount)
    begin
      wdCnt_nxt = wdCnt_r + 1'b1;
    end
  end

  // Watchdog flops
  // Reset zeroes the counter whatever the cause
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wdCnt_r <= '0;
      wdRst_r <= 1'b0;
      wdIrq_r <= 1'b0;
    end
    else
    begin
      wdCnt_r <= wdCnt_nxt;
      wdRst_r <= wdRst_nxt;
      wdIrq_r <= wdIrq_nxt;
    end
  end

  // Outputs toward the core
  // Wake request is masked outside stop mode
  assign wdResetOut = wdRst_r;
  assign wdIrq      = wdIrq_r && stop_r;

endmodule

// ==== test/scwd_analog_model.sv ====
// Analog side seen by the block: overcurrent and level sensors
// Faults and levels are requested by the testbench
`timescale 1ns/1ns

module scwd_analog_model (
  input  wire scwd_pkg::scwd_stage_s stage,
  input  wire logic [2:0]            faultReq,
  input  wire logic [3:0]            levelReq,
  output scwd_pkg::scwd_sense_s      sense
);
  // Overcurrent only flows through a stage that is on
  assign sense = {faultReq & {stage.hvddEnable, stage.highSideEnable,
                              stage.lowSideEnable}, levelReq};
endmodule

// ==== test/scwd_assertions.sv ====
// Port checker of the control and watchdog block
// Bound to the top module from the testbench file
`timescale 1ns/1ns

module scwd_checker (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire scwd_pkg::scwd_sense_s sense,
  input wire logic                  cpuIrqReq,
  input wire scwd_pkg::scwd_stage_s stage,
  input wire logic                  stopMode,
  input wire logic                  wdResetOut,
  input wire logic                  wdIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Protection and gating of the stages
  a_switched_supply_output_oc_off: assert property (sense.hvddOverCur |=> !stage.hvddEnable)
    else $error("switched output on after overcurrent");
  a_high_off: assert property (sense.highOverCur |=> !stage.highSideEnable)
    else $error("high side on after overcurrent");
  a_low_off: assert property (sense.lowOverCur |=> !stage.lowSideEnable)
    else $error("low side on after overcurrent");
  a_stages_gated: assert property (stage.hvddEnable |-> stage.linTxEnable)
    else $error("stages not gated together");

  // Stop mode and watchdog outputs
  a_wake_in_stop: assert property (wdIrq |-> stopMode)
    else $error("wake request outside stop");
  a_wake_ends_stop: assert property (wdIrq |=> !stopMode)
    else $error("stop kept after wake request");
  a_stop_exit: assert property ($fell(stopMode) |-> $past(cpuIrqReq) || $past(wdIrq))
    else $error("stop left without a request");
  a_pulse_single: assert property (wdResetOut |=> !wdResetOut)
    else $error("reset pulse too long");
  a_pulse_in_run: assert property (wdResetOut |-> !$past(stopMode))
    else $error("reset pulse from stop mode");

  // Bus answer
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_bus_okay: assert property (!hresp)
    else $error("response not okay");
endmodule

// ==== test/testbench.sv ====
// Register tests of the control and watchdog block
// Drives AHB-Lite as the only master; short watchdog periods
`timescale 1ns/1ns

module testbench;
  localparam int          FAST   = 20;
  localparam int          SLOW   = 40;
  localparam logic [31:0] A_CTRL = 32'h0000_000c;
  localparam logic [31:0] A_WD   = 32'h0000_0028;
  localparam logic [31:0] A_STAT = 32'h0000_0030;
  logic                  core_clk, rst, hsel, hwrite, cpuIrqReq;
  logic                  hreadyout, hresp, stopMode, wdResetOut, wdIrq;
  logic [1:0]            htrans;
  logic [2:0]            hsize, faultReq;
  logic [3:0]            levelReq;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  scwd_pkg::scwd_sense_s sense;
  scwd_pkg::scwd_stage_s stage;
  int                    fail_count, checks, n, c;
  int                    pulses = 0;
  logic [7:0]            flagOf [3] = '{8'h02, 8'h02, 8'h20};
  logic [5:0]            stageOf [3] = '{6'h34, 6'h2c, 6'h1c};

  scwd_top #(.WD_FAST(FAST), .WD_SLOW(SLOW)) scwd_top_i (.core_clk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .sense, .cpuIrqReq, .stage, .stopMode, .wdResetOut, .wdIrq);
  scwd_analog_model scwd_analog_model_i (.stage, .faultReq, .levelReq, .sense);

  // Clock and watchdog pulse counter
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wdResetOut === 1'b1) pulses <= pulses + 1;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a level, ends the run when it never comes
  task automatic waitHigh(ref logic s, input int lim);
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (s !== 1'b1 && c < lim);
    if (s !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitHigh(hreadyout, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    waitHigh(hreadyout, 20);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Cycles to the next watchdog pulse, checked against a period
  task automatic period(input int p);
    n = pulses;
    c = 0;
    while (pulses == n && c < 200)
    begin
      @(posedge core_clk);
      c++;
    end
    chk(c >= p - 2 && c <= p + 4, 1);
  endtask

  initial
  begin
    rst = 1'b1;
    {hsel, htrans, haddr, hwrite, hwdata, cpuIrqReq, faultReq, levelReq} = '0;
    hsize = 3'h2;
    fail_count = 0;
    checks = 0;
    cycles(10);
    rst <= 1'b0;
    cycles(1);
    rdchk(A_CTRL, 0);
    rdchk(A_WD, 0);
    rdchk(A_STAT, 0);
    chk({26'h0, stage}, 0);
    $display("test reset done");
    for (int e = 0; e < 4; e++)
    begin
      wr(A_CTRL, 8'h80 + 8'(e * 32));
      rdchk(A_CTRL, 32'h80 + e * 32);
      chk({26'h0, stage}, 32'h3c + e);
    end
    wr(A_CTRL, 8'h00);
    cycles(1);
    chk({26'h0, stage}, 0);
    wr(A_CTRL, 8'h80);
    $display("test control done");
    for (int f = 0; f < 3; f++)
    begin
      faultReq <= 3'b001 << f;
      cycles(2);
      chk({26'h0, stage}, stageOf[f]);
      faultReq <= 3'b000;
      wr(A_STAT, 8'h00);
      rdchk(A_STAT, flagOf[f]);
      wr(A_STAT, flagOf[f]);
      rdchk(A_STAT, 0);
      chk({26'h0, stage}, 32'h3c);
    end
    $display("test overcurrent done");
    levelReq <= 4'hf;
    rdchk(A_STAT, 32'h4d);
    levelReq <= 4'ha;
    rdchk(A_STAT, 32'h44);
    wr(A_CTRL, 8'h00);
    levelReq <= 4'h0;
    wr(32'h0000_0004, 8'hff);
    rdchk(32'h0000_0004, 0);
    $display("test status done");
    wr(A_WD, 8'h10);
    n = pulses;
    repeat (6)
    begin
      cycles(25);
      wr(A_WD, 8'h30);
    end
    chk(pulses, n);
    wr(A_WD, 8'h00);
    rdchk(A_WD, 32'h10);
    wr(A_WD, 8'h30);
    period(SLOW);
    wr(A_WD, 8'h31);
    period(FAST);
    $display("test watchdog done");
    wr(A_WD, 8'h31);
    wr(A_CTRL, 8'h01);
    cycles(1);
    chk(stopMode, 1);
    n = pulses;
    cycles(3 * FAST);
    chk(pulses, n);
    rdchk(A_CTRL, 0);
    cpuIrqReq <= 1'b1;
    cycles(1);
    cpuIrqReq <= 1'b0;
    cycles(1);
    chk(stopMode, 0);
    period(FAST - 2);
    $display("test stop done");
    rst <= 1'b1;
    cycles(3);
    rst <= 1'b0;
    cycles(1);
    rdchk(A_WD, 0);
    wr(A_CTRL, 8'h01);
    n = pulses;
    cycles(3 * SLOW);
    chk(pulses, n);
    chk(wdIrq, 0);
    wr(A_WD, 8'h09);
    waitHigh(wdIrq, 100);
    chk(c <= FAST + 4, 1);
    cycles(2);
    chk(stopMode, 0);
    $display("test wake done");
    give_verdict();
  end
endmodule

bind scwd_top scwd_checker scwd_checker_i (.core_clk, .rst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .sense, .cpuIrqReq, .stage, .stopMode, .wdResetOut, .wdIrq);
